/* rtl/ioic_consts.svh */
// Constants for the I/O board interrupt controller
// Assumes inclusion by the package and design modules only
`ifndef IOIC_CONSTS_SVH
`define IOIC_CONSTS_SVH
`define IOIC_LEVELS        16
`define IOIC_LVL_W         4
`define IOIC_LVL_UNUSED    4'h0
`define IOIC_LVL_SCSI      4'h1
`define IOIC_LVL_PAGEOVF   4'h3
`define IOIC_LVL_MONO      4'h5
`define IOIC_LVL_ETHER     4'h7
`define IOIC_LVL_SERIAL    4'h9
`define IOIC_LVL_KBD       4'hb
`define IOIC_LVL_SYSTIM    4'hd
`define IOIC_LVL_PROFTIM   4'hf
`define IOIC_PAGE_W        12
`define IOIC_VEC_BASE      8'h40
`define IOIC_KBD_REL_BYTES 2'h2
`endif

/* rtl/ioic_pkg.sv */
// Types shared by the interrupt controller files
// Assumes ioic_consts.svh sits in the include path
`include "ioic_consts.svh"
package ioic_pkg;
    typedef struct packed {
        logic                    valid;
        logic [`IOIC_LVL_W-1:0] level;
        logic [7:0]              vector;
    } ioic_vec_t;
    typedef enum logic [2:0] {
        IOIC_IDLE = 3'b001,
        IOIC_POST = 3'b010,
        IOIC_WAIT = 3'b100
    } ioic_state_t;
endpackage

/* rtl/ioic_dma_addr.sv */
// SCSI DMA address counter that halts at page boundaries
// Assumes step pulses come from DMA logic on the same clock
`timescale 1ns/100ps
`include "ioic_consts.svh"
module ioic_dma_addr
    import ioic_pkg::*;
#(
    parameter int ADDR_W = 32,
    parameter int PAGE_W = `IOIC_PAGE_W
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    // CPU load of the next page address
    input  wire logic              load,
    input  wire logic [ADDR_W-1:0] load_addr,
    // Byte step request from the SCSI side
    input  wire logic              step,
    // Status
    output logic      [ADDR_W-1:0] addr_q,
    output logic                   halted_q,
    output logic                   overflow
);
    initial begin
        if (PAGE_W < 1 || PAGE_W >= ADDR_W) $error("ioic_dma_addr: bad PAGE_W");
    end

    logic last_in_page;
    assign last_in_page = &addr_q[PAGE_W-1:0];
    // Crossing would leave the page: stop instead and raise the level
    assign overflow = step && !halted_q && !load && last_in_page;

    // Address count; CPU load wins and releases the halt
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= '0;
        end else if (load) begin
            addr_q <= load_addr;
        end else if (step && !halted_q && !last_in_page) begin
            addr_q <= addr_q + ADDR_W'(1);
        end
    end

    // Halt holds until software reloads the counter
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            halted_q <= 1'b0;
        end else if (load) begin
            halted_q <= 1'b0;
        end else if (overflow) begin
            halted_q <= 1'b1;
        end
    end
endmodule

/* rtl/ioic_top.sv */
// Interrupt controller on the slow peripheral bus
// Assumes same-clock sources except the raw pin requests
`timescale 1ns/100ps
`include "ioic_consts.svh"
module ioic_top
    import ioic_pkg::*;
#(
    parameter int    ADDR_W   = 32,
    parameter int    PAGE_W   = `IOIC_PAGE_W,
    parameter logic [7:0] VEC_BASE = `IOIC_VEC_BASE
) (
    // Clock and reset
    clock,
    rst_n,
    // Asynchronous device requests, one-cycle or level edges
    vme_irq,
    scsi_irq,
    mono_irq,
    ether_irq,
    serial_irq,
    sys_timer_irq,
    prof_timer_irq,
    // Keyboard byte strobe, same clock
    kbd_byte,
    // SCSI DMA counter
    dma_step,
    dma_load,
    dma_load_addr,
    dma_addr,
    dma_halted,
    // System bus request and acknowledge
    irq_req,
    irq_level,
    irq_ack,
    // Slow bus vector read
    vector_bus,
    vector_valid
);
    input  wire logic              clock;
    input  wire logic              rst_n;
    input  wire logic [7:1]        vme_irq;
    input  wire logic              scsi_irq;
    input  wire logic              mono_irq;
    input  wire logic              ether_irq;
    input  wire logic              serial_irq;
    input  wire logic              sys_timer_irq;
    input  wire logic              prof_timer_irq;
    input  wire logic              kbd_byte;
    input  wire logic              dma_step;
    input  wire logic              dma_load;
    input  wire logic [ADDR_W-1:0] dma_load_addr;
    output logic      [ADDR_W-1:0] dma_addr;
    output logic                   dma_halted;
    output logic                   irq_req;
    output logic [`IOIC_LVL_W-1:0] irq_level;
    input  wire logic              irq_ack;
    output logic [7:0]             vector_bus;
    output logic                   vector_valid;

    localparam int NLVL = `IOIC_LEVELS;
    initial begin
        if (NLVL != 16) $error("ioic_top: level count must be sixteen");
    end

    // Reset release through two flops
    logic [1:0] rst_sync_q;
    logic       rst_i_n;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) rst_sync_q <= 2'b00;
        else        rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_i_n = rst_sync_q[1];

    // Pin requests pass two flops before any logic
    logic [12:0] pin_s1_q, pin_s2_q, pin_s3_q;
    always_ff @(posedge clock or negedge rst_i_n) begin
        if (!rst_i_n) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= {prof_timer_irq, sys_timer_irq, serial_irq, ether_irq,
                         mono_irq, scsi_irq, vme_irq};
            pin_s2_q <= pin_s1_q;
        end
    end
    // Rising edge history, reads only the second stage
    always_ff @(posedge clock or negedge rst_i_n) begin
        if (!rst_i_n) pin_s3_q <= '0;
        else          pin_s3_q <= pin_s2_q;
    end
    logic [12:0] pin_rise;
    assign pin_rise = pin_s2_q & ~pin_s3_q;

    // DMA page counter supplies the page-overflow source
    logic page_ovf;
    ioic_dma_addr #(
        .ADDR_W (ADDR_W),
        .PAGE_W (PAGE_W)
    ) u_dma (
        .clock     (clock),
        .rst_n     (rst_i_n),
        .load      (dma_load),
        .load_addr (dma_load_addr),
        .step      (dma_step),
        .addr_q    (dma_addr),
        .halted_q  (dma_halted),
        .overflow  (page_ovf)
    );

    // Map each source onto its own level
    logic [NLVL-1:0] set_lvl;
    always_comb begin
        set_lvl = '0;
        for (int i = 1; i <= 7; i++) begin
            set_lvl[2*i] = pin_rise[i-1];
        end
        set_lvl[`IOIC_LVL_SCSI]    = pin_rise[7];
        set_lvl[`IOIC_LVL_PAGEOVF] = page_ovf;
        set_lvl[`IOIC_LVL_MONO]    = pin_rise[8];
        set_lvl[`IOIC_LVL_ETHER]   = pin_rise[9];
        set_lvl[`IOIC_LVL_SERIAL]  = pin_rise[10];
        set_lvl[`IOIC_LVL_KBD]     = kbd_byte;
        set_lvl[`IOIC_LVL_SYSTIM]  = pin_rise[11];
        set_lvl[`IOIC_LVL_PROFTIM] = pin_rise[12];
        set_lvl[`IOIC_LVL_UNUSED]  = 1'b0;
    end

    // Highest set bit among eight, used for both halves
    function automatic logic [3:0] ioic_pick8(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int k = 0; k < 8; k++) begin
            if (v[k]) r = {1'b1, 3'(k)};
        end
        return r;
    endfunction

    // Pending flags; set beats the acceptance clear
    logic [NLVL-1:0] pend_q;
    logic [NLVL-1:0] clr_lvl;
    always_ff @(posedge clock or negedge rst_i_n) begin
        if (!rst_i_n) pend_q <= '0;
        else          pend_q <= (pend_q & ~clr_lvl) | set_lvl;
    end

    // Even and odd selectors feed the priority scan
    logic [7:0] even_v, odd_v;
    logic [3:0] even_p, odd_p;
    always_comb begin
        for (int j = 0; j < 8; j++) begin
            even_v[j] = pend_q[2*j];
            odd_v[j]  = pend_q[2*j+1];
        end
    end
    assign even_p = ioic_pick8(even_v);
    assign odd_p  = ioic_pick8(odd_v);

    // Descending scan: compare best even and best odd
    logic       any_pend;
    logic [3:0] top_lvl;
    always_comb begin
        any_pend = even_p[3] | odd_p[3];
        if (odd_p[3] && (!even_p[3] || odd_p[2:0] >= even_p[2:0])) begin
            top_lvl = {odd_p[2:0], 1'b1};
        end else begin
            top_lvl = {even_p[2:0], 1'b0};
        end
    end

    // Request and vector sequencing
    ioic_state_t state_q;
    ioic_vec_t   post_q;
    always_ff @(posedge clock or negedge rst_i_n) begin
        if (!rst_i_n) begin
            state_q <= IOIC_IDLE;
        end else begin
            case (state_q)
                IOIC_IDLE: if (any_pend) state_q <= IOIC_POST;
                IOIC_POST: if (irq_ack)  state_q <= IOIC_WAIT;
                IOIC_WAIT: state_q <= IOIC_IDLE;
                default:   state_q <= IOIC_IDLE;
            endcase
        end
    end

    // Level is frozen while offered so the ack matches it
    always_ff @(posedge clock or negedge rst_i_n) begin
        if (!rst_i_n) begin
            post_q <= '0;
        end else if (state_q == IOIC_IDLE && any_pend) begin
            post_q.level <= top_lvl;
        end else if (state_q == IOIC_POST && irq_ack) begin
            post_q.valid  <= 1'b1;
            post_q.vector <= VEC_BASE | {4'h0, post_q.level};
        end
    end

    // Clear exactly the accepted level
    always_comb begin
        clr_lvl = '0;
        if (state_q == IOIC_POST && irq_ack) clr_lvl[post_q.level] = 1'b1;
    end

    assign irq_req      = (state_q == IOIC_POST);
    assign irq_level    = post_q.level;
    assign vector_bus   = post_q.vector;
    assign vector_valid = post_q.valid;
endmodule

/* dv/ioic_top_sva.sv */
// Port checker for the interrupt controller
// Assumes default widths and one clock with async active-low reset
`timescale 1ns/100ps
module ioic_top_sva #(
    parameter int         ADDR_W   = 32,
    parameter int         PAGE_W   = 12,
    parameter logic [7:0] VEC_BASE = 8'h40
) (
    // Clock and reset
    input wire logic              clock,
    input wire logic              rst_n,
    // Keyboard and DMA
    input wire logic              kbd_byte,
    input wire logic              dma_step,
    input wire logic              dma_load,
    input wire logic [ADDR_W-1:0] dma_load_addr,
    input wire logic [ADDR_W-1:0] dma_addr,
    input wire logic              dma_halted,
    // System bus and slow bus
    input wire logic              irq_req,
    input wire logic [3:0]        irq_level,
    input wire logic              irq_ack,
    input wire logic [7:0]        vector_bus,
    input wire logic              vector_valid
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Offer side of the handshake
    a_vec_on_accept: assert property (irq_req && irq_ack |=> vector_valid &&
        vector_bus == (VEC_BASE | {4'h0, $past(irq_level)}))
        else $error("bad vector");
    a_gap_after_ack: assert property (irq_req && irq_ack |=> !irq_req ##1 !irq_req)
        else $error("no gap after accept");
    a_offer_holds: assert property (irq_req && !irq_ack |=> irq_req && $stable(irq_level))
        else $error("offer dropped before accept");
    a_level_nonzero: assert property (irq_req |-> irq_level != 4'h0)
        else $error("level zero offered");
    a_kbd_raises: assert property (kbd_byte && !irq_req |-> ##[1:4] irq_req)
        else $error("keyboard byte lost");
    // Page-stopping DMA counter
    a_page_halt: assert property (dma_step && !dma_load && (&dma_addr[PAGE_W-1:0]) |=>
        dma_halted && dma_addr == $past(dma_addr)) else $error("no halt at page end");
    a_step_adv: assert property (dma_step && !dma_load && !dma_halted
        && !(&dma_addr[PAGE_W-1:0]) |=> dma_addr == $past(dma_addr) + ADDR_W'(1))
        else $error("step not counted");
    a_halt_irq: assert property ($rose(dma_halted) |-> ##[0:4] irq_req)
        else $error("halt raised no request");
    a_load_resume: assert property (dma_load |=> !dma_halted && dma_addr == $past(dma_load_addr))
        else $error("load did not resume");
endmodule
bind ioic_top ioic_top_sva #(.ADDR_W(ADDR_W), .PAGE_W(PAGE_W), .VEC_BASE(VEC_BASE))
    ioic_top_sva_i (.clock(clock), .rst_n(rst_n), .kbd_byte(kbd_byte), .dma_step(dma_step),
    .dma_load(dma_load), .dma_load_addr(dma_load_addr), .dma_addr(dma_addr),
    .dma_halted(dma_halted), .irq_req(irq_req), .irq_level(irq_level), .irq_ack(irq_ack),
    .vector_bus(vector_bus), .vector_valid(vector_valid));

/* dv/ioic_cpu_model.sv */
// Servicing CPU: accepts offered levels and reads the vector
// Assumes irq_req holds until acknowledged
`timescale 1ns/100ps
module ioic_cpu_model (
    // Clock and offer
    input  wire logic       clock,
    input  wire logic       irq_req,
    input  wire logic [3:0] irq_level,
    input  wire logic [7:0] vector_bus,
    input  wire logic [1:0] slow,
    // Acknowledge and report
    output logic            irq_ack,
    output logic            took,
    output logic [3:0]      took_lvl,
    output logic [7:0]      took_vec
);
    initial begin
        irq_ack  = 1'h0;
        took     = 1'h0;
        took_lvl = 4'h0;
        took_vec = 8'h00;
    end
    // Stalls a few cycles; timers need nothing beyond the acknowledge
    always begin
        @(posedge clock);
        #1 took = 1'h0;
        if (irq_req === 1'b1) begin
            repeat (slow) @(posedge clock);
            #1 irq_ack = 1'h1;
            took_lvl = irq_level;
            @(posedge clock);
            #1 irq_ack = 1'h0;
            took_vec = vector_bus;
            took = 1'h1;
        end
    end
endmodule

/* dv/tb_io_board_interrupt_controller.sv */
// Bench for the interrupt controller with a pending-set model
// Assumes default parameters: 4 KB pages, vector base 8'h40
`timescale 1ns/100ps
module tb_io_board_interrupt_controller;
    logic        clock = 1'h0;
    logic        rst_n = 1'h0;
    logic [15:0] pins = 16'h0000, pend = 16'h0000;
    logic        kbd_byte = 1'h0, dma_step = 1'h0, dma_load = 1'h0;
    logic [31:0] ld_addr = 32'h0, dma_addr;
    logic        halted, irq_req, irq_ack, vvalid, took;
    logic [3:0]  irq_level, took_lvl;
    logic [7:0]  vbus, took_vec;
    logic [1:0]  slow = 2'h0;
    int          fail_count = 0, checks = 0, seed = 32'h6254, i, e;
    ioic_top ioic_top_i (.clock(clock), .rst_n(rst_n), .vme_irq({pins[14], pins[12], pins[10],
        pins[8], pins[6], pins[4], pins[2]}), .scsi_irq(pins[1]), .mono_irq(pins[5]),
        .ether_irq(pins[7]), .serial_irq(pins[9]), .sys_timer_irq(pins[13]),
        .prof_timer_irq(pins[15]), .kbd_byte(kbd_byte), .dma_step(dma_step), .dma_load(dma_load),
        .dma_load_addr(ld_addr), .dma_addr(dma_addr), .dma_halted(halted), .irq_req(irq_req),
        .irq_level(irq_level), .irq_ack(irq_ack), .vector_bus(vbus), .vector_valid(vvalid));
    ioic_cpu_model ioic_cpu_model_i (.clock(clock), .irq_req(irq_req), .irq_level(irq_level),
        .vector_bus(vbus), .slow(slow), .irq_ack(irq_ack), .took(took), .took_lvl(took_lvl),
        .took_vec(took_vec));
    always #5 clock = ~clock;
    // Wide enough that status bits packed above an address survive
    task cmp(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function int top(input logic [15:0] p);
        for (int k = 15; k > 0; k--) if (p[k]) return k;
        return 0;
    endfunction
    // Each acceptance must be the highest level still pending
    always @(posedge clock) if (took === 1'b1) begin
        e = top(pend);
        cmp(took_lvl, e);
        cmp(took_vec, 8'h40 | e);
        pend[e] = 1'b0;
    end
    // Bounded wait for the model set to empty
    task drain();
        for (int n = 0; n < 300 && pend != 16'h0000; n++) @(posedge clock);
        cmp(pend, 0);
    endtask
    task final_report();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #400000 fail_count++;
        final_report();
    end
    initial begin
        repeat (10) @(negedge clock);
        rst_n = 1'h1;
        repeat (3) @(negedge clock);
        cmp({irq_req, vvalid, halted}, 0);
        $display("reset test done");
        // Random simultaneous pin bursts; pages and keyboard have no pin
        for (i = 0; i < 20; i++) begin
            @(negedge clock);
            slow = 2'($random(seed));
            pins = 16'($random(seed));
            pend = pins & 16'hf7f6;
            repeat (4) @(negedge clock);
            pins = 16'h0000;
            drain();
        end
        cmp(vvalid, 1);
        $display("priority test done");
        // Three single keyboard bytes, each drained before the next
        repeat (3) begin
            @(negedge clock);
            kbd_byte = 1'h1;
            pend[11] = 1'b1;
            @(negedge clock);
            kbd_byte = 1'h0;
            drain();
        end
        $display("keyboard test done");
        // Reset lands after a keyboard flag is set but before it is offered
        @(negedge clock);
        kbd_byte = 1'h1;
        @(negedge clock);
        kbd_byte = 1'h0;
        rst_n = 1'h0;
        repeat (2) @(negedge clock);
        rst_n = 1'h1;
        repeat (8) @(negedge clock);
        cmp({irq_req, vvalid, took}, 0);
        $display("mid-run reset test done");
        // One step reaches the page end, the second halts, third step is ignored
        @(negedge clock);
        ld_addr = 32'h1234_0ffe;
        dma_load = 1'h1;
        @(negedge clock);
        dma_load = 1'h0;
        for (i = 0; i < 3; i++) begin
            @(negedge clock);
            dma_step = 1'h1;
            pend[3] = pend[3] | (i == 1);
            @(negedge clock);
            dma_step = 1'h0;
        end
        cmp({halted, dma_addr}, {1'b1, 32'h1234_0fff});
        drain();
        @(negedge clock);
        ld_addr = 32'h1234_1000;
        dma_load = 1'h1;
        @(negedge clock);
        dma_load = 1'h0;
        dma_step = 1'h1;
        @(negedge clock);
        dma_step = 1'h0;
        cmp({halted, dma_addr}, {1'b0, 32'h1234_1001});
        $display("dma test done");
        final_report();
    end
endmodule
